// >>> common/ccdts_pkg.sv
// Constants and types for the interline sensor readout sequencer.
package ccdts_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PS         = 25000;
    localparam int unsigned T_XFER_MIN_PS  = 3000000;
    localparam int unsigned T_XFER_NOM_PS  = 5000000;
    localparam int unsigned T_XFER_MAX_PS  = 15000000;
    localparam int unsigned T_FD_MIN_PS    = 500000;
    localparam int unsigned T_VERTICAL_SHIFT_REGISTER_NOM_PS  = 1500000;
    localparam int unsigned T_SHUT_NOM_PS  = 4000000;
    localparam int unsigned T_VE_MAX_PS    = 100000;

    localparam logic [9:0] XFER_MIN_CYC = 10'((T_XFER_MIN_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [9:0] XFER_NOM_CYC = 10'(T_XFER_NOM_PS / CLK_PS);
    localparam logic [9:0] XFER_MAX_CYC = 10'(T_XFER_MAX_PS / CLK_PS);
    localparam logic [9:0] FD_CYC       = 10'((T_FD_MIN_PS + CLK_PS - 1) / CLK_PS);
    localparam logic [9:0] VERTICAL_SHIFT_REGISTER_CYC     = 10'(T_VERTICAL_SHIFT_REGISTER_NOM_PS / CLK_PS);
    localparam logic [9:0] VERTICAL_SHIFT_REGISTER_HALF    = 10'(T_VERTICAL_SHIFT_REGISTER_NOM_PS / CLK_PS / 2);
    localparam logic [9:0] SHUT_CYC     = 10'(T_SHUT_NOM_PS / CLK_PS);
    localparam logic [9:0] VE_MAX_CYC   = 10'(T_VE_MAX_PS / CLK_PS);

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam logic [11:0] ROWS_PROG    = 12'h800;
    localparam logic [11:0] ROWS_FIELD   = 12'h40d;
    localparam logic [11:0] ROWS_BINNED  = 12'h400;
    localparam logic [11:0] PIX_PER_LINE = 12'h840;
    localparam logic [1:0]  HDIV_FULL    = 2'h1;
    localparam logic [1:0]  HDIV_HALF    = 2'h2;
    localparam int unsigned ADC_W        = 14;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PROG = 2'h0,
        MODE_SUM  = 2'h1,
        MODE_NSUM = 2'h2
    } ccdts_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SHUT   = 3'h1,
        ST_INTEG  = 3'h3,
        ST_XFER   = 3'h2,
        ST_DUMP   = 3'h6,
        ST_VSHIFT = 3'h7,
        ST_HREAD  = 3'h5,
        ST_DONE   = 3'h4
    } ccdts_state_t;

    typedef struct packed {
        logic             frame_start;
        logic             line_start;
        logic             field_odd;
        logic [11:0]      row;
        logic [ADC_W-1:0] pix;
    } ccdts_word_t;

    typedef struct packed {
        logic v1;
        logic v2;
        logic v2_xfer_even;
        logic v2_xfer_odd;
        logic h1;
        logic h2;
        logic fd;
        logic sub;
    } ccdts_phase_t;

endpackage

// >>> rtl/ccdts_top.sv
// Readout timing sequencer driving the phases of an interline image sensor.
//
// Function
// - Progressive: one transfer moves all photodiodes.
// - Summed interlaced: pairs summed in vertical register.
// - Even summed field pairs rows 0+1, 2+3.
// - Odd summed field pairs rows 1+2, 3+4.
// - Interlaced readout alternates even and odd fields.
// - Summed interlaced field needs 1037 vertical shifts.
// - Non-summed even field transfers even rows only.
// - Non-summed odd field transfers odd rows only.
// - Non-summed packets occupy two row positions.
// - Transfer pulse held 3.0 to 15.0 us.
// - Wait 0.5 us after fast dump gate.
// - Vertical edge skew within 100 ns.
// - Shutter pulse precedes transfer by integration time.
// - Full range binned modes halve pixel rate.
`timescale 1ns/1ps
module ccdts_top
    import ccdts_pkg::*;
(
    input  wire logic             CLOCK_I,
    input  wire logic             RST_I,
    input  wire logic             CE_I,
    input  wire logic             START_I,
    input  wire ccdts_mode_t      MODE_I,
    input  wire logic             FULL_RANGE_I,
    input  wire logic [9:0]       XFER_CYC_I,
    input  wire logic [23:0]      INT_CYC_I,
    input  wire logic [ADC_W-1:0] PIX_DATA_I,
    input  wire logic             OUT_READY_I,
    output ccdts_phase_t          PHASE_O,
    output logic                  FIELD_ODD_O,
    output logic                  BUSY_O,
    output logic                  OUT_VALID_O,
    output ccdts_word_t           OUT_WORD_O
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // whether the even or odd row group transfers in this mode and field
    function automatic logic xfer_group(input ccdts_mode_t m,
                                        input logic fld,
                                        input logic odd_grp);
        xfer_group = (m != MODE_NSUM) || (fld == odd_grp);
    endfunction

    ccdts_state_t state_ff;
    ccdts_state_t nxt_state;
    ccdts_mode_t  mode_ff;
    ccdts_phase_t phase_ff;
    ccdts_phase_t nxt_phase;
    ccdts_word_t  mem_ff [2];
    logic [23:0]  tcnt_ff;
    logic [23:0]  int_len_ff;
    logic [9:0]   xfer_len_ff;
    logic [11:0]  row_ff;
    logic [11:0]  col_ff;
    logic [11:0]  rows_total;
    logic [1:0]   hdiv;
    logic [1:0]   cnt_ff;
    logic [ADC_W-1:0] pix_s1_ff;
    logic [ADC_W-1:0] pix_s2_ff;
    logic         hph_ff;
    logic         frange_ff;
    logic         field_ff;
    logic         skip_ff;
    logic         wp_ff;
    logic         rp_ff;
    logic         h_last;
    logic         in_ready;
    logic         push;
    logic         pop;
    logic         line_end;

    // ------------------------------------------------------------
    // Pixel input synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            pix_s1_ff <= '0;
            pix_s2_ff <= '0;
        end else if (CE_I) begin
            pix_s1_ff <= PIX_DATA_I;
            pix_s2_ff <= pix_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Frame setup latched at start
    // ------------------------------------------------------------
    // The shutter must sit wholly inside the integration time, so the
    // programmed integration is never shorter than the shutter pulse.
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            mode_ff     <= MODE_PROG;
            frange_ff   <= 1'b0;
            xfer_len_ff <= XFER_NOM_CYC;
            int_len_ff  <= 24'(SHUT_CYC) + 24'h1;
        end else if (CE_I && state_ff == ST_IDLE && START_I) begin
            mode_ff   <= MODE_I;
            frange_ff <= FULL_RANGE_I;
            if (XFER_CYC_I < XFER_MIN_CYC) begin
                xfer_len_ff <= XFER_MIN_CYC;
            end else if (XFER_CYC_I > XFER_MAX_CYC) begin
                xfer_len_ff <= XFER_MAX_CYC;
            end else begin
                xfer_len_ff <= XFER_CYC_I;
            end
            if (INT_CYC_I <= 24'(SHUT_CYC)) begin
                int_len_ff <= 24'(SHUT_CYC) + 24'h1;
            end else begin
                int_len_ff <= INT_CYC_I;
            end
        end
    end

    assign rows_total = (mode_ff == MODE_PROG) ? ROWS_PROG : ROWS_FIELD;
    assign hdiv     = (frange_ff && mode_ff != MODE_PROG) ? HDIV_HALF : HDIV_FULL;
    assign h_last   = (tcnt_ff == 24'(hdiv) - 24'h1);
    assign in_ready = (cnt_ff != 2'h2);
    assign push     = (state_ff == ST_HREAD) && hph_ff && h_last && in_ready;
    assign line_end = push && (col_ff == PIX_PER_LINE - 12'h1);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (START_I) begin
                    nxt_state = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (tcnt_ff == 24'(SHUT_CYC) - 24'h1) begin
                    nxt_state = ST_INTEG;
                end
            end
            ST_INTEG: begin
                if (tcnt_ff >= int_len_ff - 24'h1) begin
                    nxt_state = ST_XFER;
                end
            end
            ST_XFER: begin
                if (tcnt_ff == 24'(xfer_len_ff) - 24'h1) begin
                    nxt_state = ST_DUMP;
                end
            end
            ST_DUMP: begin
                if (tcnt_ff == 24'(FD_CYC) + 24'(FD_CYC) - 24'h1) begin
                    nxt_state = ST_VSHIFT;
                end
            end
            ST_VSHIFT: begin
                if (tcnt_ff == 24'(VERTICAL_SHIFT_REGISTER_CYC) - 24'h1) begin
                    nxt_state = skip_ff ? ST_VSHIFT : ST_HREAD;
                end
            end
            ST_HREAD: begin
                if (line_end) begin
                    nxt_state = (row_ff == rows_total - 12'h1) ? ST_DONE : ST_VSHIFT;
                end
            end
            ST_DONE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_ff <= ST_IDLE;
        end else if (CE_I) begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Duration counter and horizontal divider
    // ------------------------------------------------------------
    // The counter runs on from the shutter into integration, so the
    // integration time is measured from the shutter pulse start.
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            tcnt_ff <= '0;
            hph_ff  <= 1'b0;
        end else if (CE_I) begin
            if (state_ff == ST_HREAD && nxt_state == ST_HREAD) begin
                if (!h_last) begin
                    tcnt_ff <= tcnt_ff + 24'h1;
                end else if (!hph_ff || in_ready) begin
                    tcnt_ff <= '0;
                    hph_ff  <= ~hph_ff;
                end
            end else if (nxt_state != state_ff &&
                         !(state_ff == ST_SHUT && nxt_state == ST_INTEG)) begin
                tcnt_ff <= '0;
                hph_ff  <= 1'b0;
            end else if (state_ff == ST_VSHIFT) begin
                tcnt_ff <= (tcnt_ff == 24'(VERTICAL_SHIFT_REGISTER_CYC) - 24'h1) ? '0 : tcnt_ff + 24'h1;
            end else if (state_ff != ST_IDLE) begin
                tcnt_ff <= tcnt_ff + 24'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Row, column and field tracking
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            row_ff   <= '0;
            col_ff   <= '0;
            field_ff <= 1'b0;
            skip_ff  <= 1'b0;
        end else if (CE_I) begin
            if (state_ff == ST_IDLE && START_I) begin
                row_ff <= '0;
                col_ff <= '0;
                if (MODE_I == MODE_PROG) begin
                    field_ff <= 1'b0;
                end
                skip_ff <= (MODE_I == MODE_SUM) && field_ff;
            end
            if (state_ff == ST_VSHIFT && tcnt_ff == 24'(VERTICAL_SHIFT_REGISTER_CYC) - 24'h1) begin
                skip_ff <= 1'b0;
            end
            if (push) begin
                col_ff <= line_end ? 12'h0 : col_ff + 12'h1;
            end
            if (line_end) begin
                row_ff <= row_ff + 12'h1;
            end
            if (state_ff == ST_DONE && mode_ff != MODE_PROG) begin
                field_ff <= ~field_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // Sensor phases
    // ------------------------------------------------------------
    always_comb begin
        nxt_phase    = '0;
        nxt_phase.v2_xfer_even = (state_ff == ST_XFER) && xfer_group(mode_ff, field_ff, 1'b0);
        nxt_phase.v2_xfer_odd  = (state_ff == ST_XFER) && xfer_group(mode_ff, field_ff, 1'b1);
        nxt_phase.v1  = (state_ff == ST_VSHIFT) && (tcnt_ff < 24'(VERTICAL_SHIFT_REGISTER_HALF));
        nxt_phase.v2  = ((state_ff == ST_VSHIFT) && (tcnt_ff >= 24'(VERTICAL_SHIFT_REGISTER_HALF))) ||
                        (state_ff == ST_XFER);
        nxt_phase.h1  = (state_ff == ST_HREAD) && !hph_ff;
        nxt_phase.h2  = (state_ff == ST_HREAD) && hph_ff;
        nxt_phase.fd  = (state_ff == ST_DUMP) && (tcnt_ff < 24'(FD_CYC));
        nxt_phase.sub = (state_ff == ST_SHUT);
    end

    // aligned edges
    // Every phase leaves one flop bank on one edge, so skew between
    // phases is only the pad and board mismatch, far below the limit.
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            phase_ff <= '0;
        end else if (CE_I) begin
            phase_ff <= nxt_phase;
        end
    end

    // ------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------
    // A full buffer stalls the horizontal clock itself, so a slow
    // receiver costs line time but never a pixel.
    assign pop = (cnt_ff != 2'h0) && OUT_READY_I;

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            wp_ff     <= 1'b0;
            rp_ff     <= 1'b0;
            cnt_ff    <= 2'h0;
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (CE_I) begin
            if (push) begin
                mem_ff[wp_ff] <= '{frame_start: (row_ff == 12'h0) && (col_ff == 12'h0),
                                   line_start:  (col_ff == 12'h0),
                                   field_odd:   field_ff,
                                   row:         row_ff,
                                   pix:         pix_s2_ff};
                wp_ff <= ~wp_ff;
            end
            if (pop) begin
                rp_ff <= ~rp_ff;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign PHASE_O     = phase_ff;
    assign FIELD_ODD_O = field_ff;
    assign BUSY_O      = (state_ff != ST_IDLE);
    assign OUT_VALID_O = (cnt_ff != 2'h0);
    assign OUT_WORD_O  = mem_ff[rp_ff];

endmodule

// >>> verif/ccdts_top_properties.sv
// Port-level timing checks for the readout sequencer.
`timescale 1ns/1ps
module ccdts_top_properties
    import ccdts_pkg::*;
(
    input wire logic             CLOCK_I,
    input wire logic             RST_I,
    input wire logic             CE_I,
    input wire logic             START_I,
    input wire ccdts_mode_t      MODE_I,
    input wire logic             FULL_RANGE_I,
    input wire logic [9:0]       XFER_CYC_I,
    input wire logic [23:0]      INT_CYC_I,
    input wire logic [ADC_W-1:0] PIX_DATA_I,
    input wire logic             OUT_READY_I,
    input wire ccdts_phase_t     PHASE_O,
    input wire logic             FIELD_ODD_O,
    input wire logic             BUSY_O,
    input wire logic             OUT_VALID_O,
    input wire ccdts_word_t      OUT_WORD_O
);
    // ------
    // Helpers
    // ------
    logic [9:0]  sub_cnt_ff;
    logic [9:0]  xfer_cnt_ff;
    logic [9:0]  gap_cnt_ff;
    ccdts_mode_t mode_ff;
    logic        xfer;
    assign xfer = PHASE_O.v2_xfer_even | PHASE_O.v2_xfer_odd;
    always_ff @(posedge CLOCK_I) begin
        sub_cnt_ff <= (RST_I || !PHASE_O.sub) ? 10'h000 : sub_cnt_ff + 10'h001;
    end
    always_ff @(posedge CLOCK_I) begin
        xfer_cnt_ff <= (RST_I || !xfer) ? 10'h000 : xfer_cnt_ff + 10'h001;
    end
    // The gap counter saturates so that later rows never wrap it.
    always_ff @(posedge CLOCK_I) begin
        gap_cnt_ff <= (RST_I || PHASE_O.fd) ? 10'h000
                      : gap_cnt_ff + {9'h000, gap_cnt_ff != 10'h3ff};
    end
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            mode_ff <= MODE_PROG;
        end else if (START_I && CE_I && !BUSY_O) begin
            mode_ff <= MODE_I;
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence s_taken;
        START_I && CE_I && !BUSY_O;
    endsequence
    sequence s_launch;
        BUSY_O ##1 PHASE_O.sub;
    endsequence
    a_start_launch: assert property (s_taken |=> s_launch)
        else $error("shutter did not follow start");
    a_shutter_width: assert property ($fell(PHASE_O.sub) |-> sub_cnt_ff == 10'h0a0)
        else $error("shutter width wrong");
    a_xfer_window: assert property ($fell(xfer) |->
        xfer_cnt_ff >= 10'h078 && xfer_cnt_ff <= 10'h258)
        else $error("transfer width outside window");
    a_xfer_phase: assert property (xfer |-> PHASE_O.v2 && !PHASE_O.v1)
        else $error("transfer off second phase");
    a_dump_gap: assert property ($rose(PHASE_O.v1) |-> gap_cnt_ff >= 10'h014)
        else $error("vertical shift too soon after dump");
    a_edge_skew: assert property ($fell(PHASE_O.v1) |-> ##[0:4] PHASE_O.v2)
        else $error("vertical edges misaligned");
    a_group_full: assert property (xfer && mode_ff != MODE_NSUM |->
        PHASE_O.v2_xfer_even && PHASE_O.v2_xfer_odd)
        else $error("not all rows transferred");
    a_group_half: assert property (xfer && mode_ff == MODE_NSUM |->
        PHASE_O.v2_xfer_odd == FIELD_ODD_O && PHASE_O.v2_xfer_even != FIELD_ODD_O)
        else $error("wrong row group transferred");
    a_stall_hold: assert property (OUT_VALID_O && !OUT_READY_I |=>
        OUT_VALID_O && $stable(OUT_WORD_O))
        else $error("word changed while stalled");
    a_reset_clear: assert property ($fell(RST_I) |->
        PHASE_O == 8'h00 && !BUSY_O && !OUT_VALID_O && !FIELD_ODD_O)
        else $error("outputs not cleared by reset");
endmodule

bind ccdts_top ccdts_top_properties u_props (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .START_I(START_I), .MODE_I(MODE_I),
    .FULL_RANGE_I(FULL_RANGE_I), .XFER_CYC_I(XFER_CYC_I), .INT_CYC_I(INT_CYC_I),
    .PIX_DATA_I(PIX_DATA_I), .OUT_READY_I(OUT_READY_I), .PHASE_O(PHASE_O),
    .FIELD_ODD_O(FIELD_ODD_O), .BUSY_O(BUSY_O), .OUT_VALID_O(OUT_VALID_O),
    .OUT_WORD_O(OUT_WORD_O)
);

// >>> verif/ccdts_sensor_model.sv
// Behavioural image sensor answering the sequencer's phase outputs.
`timescale 1ns/1ps
module ccdts_sensor_model
    import ccdts_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire ccdts_phase_t phase_i,
    output logic [ADC_W-1:0]  pix_o
);
    logic [11:0]      shift_cnt_ff = 12'h000;
    logic             v1_ff        = 1'b0;
    logic [ADC_W-1:0] level;
    always_ff @(posedge clk_i) begin
        v1_ff <= phase_i.v1;
        if (rst_i || phase_i.v2_xfer_even || phase_i.v2_xfer_odd) begin
            shift_cnt_ff <= 12'h000;
        end else if (phase_i.v1 && !v1_ff) begin
            shift_cnt_ff <= shift_cnt_ff + 12'h001;
        end
    end
    assign level = 14'(shift_cnt_ff * 3 + 5);
    // While V1 is high the output is not valid, so it shows the inverse.
    assign pix_o = phase_i.v1 ? ~level : level;
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the readout sequencer.
`timescale 1ns/1ps
module testbench;
    import ccdts_pkg::*;
    logic             clock = 1'b0;
    logic             rst = 1'b1;
    logic             ce = 1'b1;
    logic             start = 1'b0;
    ccdts_mode_t      mode = MODE_PROG;
    logic             full_range = 1'b0;
    logic [9:0]       xfer_cyc = 10'h000;
    logic [23:0]      int_cyc = 24'h000000;
    logic [ADC_W-1:0] pix_data;
    logic             out_ready = 1'b0;
    ccdts_phase_t     phase;
    logic             field_odd;
    logic             busy;
    logic             out_valid;
    ccdts_word_t      out_word;
    int               fails = 0;
    int               total_checks = 0;
    int               seed = 10;
    int               cycles = 0;
    logic             stall = 1'b0;
    ccdts_word_t      got_q[$];
    ccdts_mode_t      modes[3] = '{MODE_PROG, MODE_SUM, MODE_NSUM};

    ccdts_top DUT (.CLOCK_I(clock), .RST_I(rst), .CE_I(ce), .START_I(start), .MODE_I(mode),
        .FULL_RANGE_I(full_range), .XFER_CYC_I(xfer_cyc), .INT_CYC_I(int_cyc),
        .PIX_DATA_I(pix_data), .OUT_READY_I(out_ready), .PHASE_O(phase),
        .FIELD_ODD_O(field_odd), .BUSY_O(busy), .OUT_VALID_O(out_valid), .OUT_WORD_O(out_word));
    ccdts_sensor_model u_sensor (.clk_i(clock), .rst_i(rst), .phase_i(phase), .pix_o(pix_data));

    always #12.5 clock = ~clock;
    // The ceiling leaves ample margin over the planned run of some 12000 cycles.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            end_of_test();
        end
    end
    always @(posedge clock) begin
        if (!rst && ce === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
            got_q.push_back(out_word);
        end
        #1 out_ready = stall ? 1'b0 : 1'($random(seed));
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_word(input ccdts_word_t got, input ccdts_word_t exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_lvl(input int b, input logic lv, output int n);
        n = 0;
        while (phase[b] !== lv && n < 20000) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    function automatic int exp_xfer(input int x);
        return (x < 120) ? 120 : (x > 600) ? 600 : x;
    endfunction
    function automatic ccdts_word_t exp_word(input int i);
        ccdts_word_t w;
        w.frame_start = (i == 0);
        w.line_start = (i % 2112 == 0);
        w.field_odd = 1'b0;
        w.row = 12'(i / 2112);
        w.pix = 14'(3 * (i / 2112 + 1) + 5);
        return w;
    endfunction

    task automatic run_frame(input ccdts_mode_t m, input logic fr, input logic [9:0] x,
                             input logic [23:0] ic, input int nw);
        int n;
        ccdts_phase_t hold;
        ccdts_word_t  hold_w;
        got_q.delete();
        {start, mode, full_range, xfer_cyc, int_cyc} = {1'b1, m, fr, x, ic};
        @(posedge clock);
        #1 start = 1'b0;
        check_val(32'(busy), 32'h1);
        wait_lvl(0, 1'b1, n);
        check_val(n, 1);
        wait_lvl(5, 1'b1, n);
        check_val(n, (ic <= 160) ? 161 : ic);
        check_val({phase.v2, phase.v2_xfer_odd}, {1'b1, m != MODE_NSUM});
        wait_lvl(5, 1'b0, n);
        check_val(n, exp_xfer(x));
        wait_lvl(1, 1'b1, n);
        wait_lvl(1, 1'b0, n);
        check_val(n, 20);
        wait_lvl(3, 1'b1, n);
        wait_lvl(3, 1'b0, n);
        check_val(n, (fr && m != MODE_PROG) ? 2 : 1);
        start = 1'b1;
        mode = modes[(m + 1) % 3];
        @(posedge clock);
        #1 start = 1'b0;
        repeat (3) @(posedge clock);
        #1 check_val({phase.sub, busy, field_odd}, 3'h2);
        // A low clock enable must freeze the phases and the buffer head.
        hold = phase;
        hold_w = out_word;
        ce = 1'b0;
        repeat (3) @(posedge clock);
        #1 check_val(phase, hold);
        check_word(out_word, hold_w);
        ce = 1'b1;
        stall = 1'b1;
        repeat (40) @(posedge clock);
        #1 check_val({out_valid, phase.h2}, 2'h3);
        stall = 1'b0;
        n = 0;
        while (got_q.size() < nw && n < 30000) begin
            @(posedge clock);
            n++;
        end
        #1 check_val(got_q.size() >= nw, 1);
        for (int i = 0; i < nw && i < got_q.size(); i++) begin
            check_word(got_q[i], exp_word(i));
        end
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        check_val({busy, out_valid, phase}, 10'h000);
    endtask

    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clock);
        #1 rst = 1'b0;
        run_frame(MODE_PROG, 1'b1, 10'h032, 24'h000000, 2114);
        run_frame(MODE_NSUM, 1'b0, 10'h3e8, 24'h0000a1, 3);
        run_frame(MODE_SUM, 1'b1, 10'h258, 24'h0000a0, 3);
        for (int k = 0; k < 3; k++) begin
            run_frame(modes[k], 1'($random(seed)), 10'(120 + $unsigned($random(seed)) % 481),
                      24'(161 + $unsigned($random(seed)) % 2000), 3);
        end
        end_of_test();
    end
endmodule
